//--- ptg_pkg.sv
/*
  Package for the periodic tick generator: register map, field layout,
  reset values, divider taps and bus carrier types.
  Assumes a 32-bit AXI4-Lite register bus on a single 200 MHz clock.
*/
package ptg_pkg;

  localparam int unsigned AW = 4;
  localparam int unsigned DW = 32;

  // Register byte offsets
  localparam logic [AW-1:0] TICK_CONTROL_OFF = 4'h0;
  localparam logic [AW-1:0] TICK_COUNT_OFF   = 4'h4;

  // Field positions in tick_control
  localparam int unsigned TICK_FLAG_POS  = 7;
  localparam int unsigned TAP_SEL_LSB    = 4;
  localparam int unsigned TICK_ACK_POS   = 3;
  localparam int unsigned TICK_IRQEN_POS = 2;
  localparam int unsigned TICK_RUN_POS   = 1;

  localparam logic [2:0] TAP_SEL_RST   = 3'h0;
  localparam logic       TICK_RUN_RST  = 1'b0;
  localparam logic       TICK_IRQEN_RST = 1'b0;

  // Divider chain
  localparam int unsigned DIV_STAGES = 15;
  localparam int unsigned PRE_STAGES = 7;
  localparam logic [PRE_STAGES-1:0] PRE_ZERO = 7'h00;
  localparam logic [DIV_STAGES-1:0] DIV_ZERO = 15'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic          awvalid;
    logic [AW-1:0] awaddr;
    logic          wvalid;
    logic [DW-1:0] wdata;
    logic [3:0]    wstrb;
    logic          bready;
    logic          arvalid;
    logic [AW-1:0] araddr;
    logic          rready;
  } ptg_axi_req_t;

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [DW-1:0] rdata;
    logic [1:0]    rresp;
  } ptg_axi_rsp_t;

  // Tap bit index of the 15-stage chain for each select code
  function automatic logic [3:0] ptg_tap_bit(input logic [2:0] sel);
    unique case (sel)
      3'h0: ptg_tap_bit = 4'he;
      3'h1: ptg_tap_bit = 4'hc;
      3'h2: ptg_tap_bit = 4'ha;
      3'h3: ptg_tap_bit = 4'h6;
      3'h4: ptg_tap_bit = 4'h5;
      3'h5: ptg_tap_bit = 4'h4;
      3'h6: ptg_tap_bit = 4'h3;
      3'h7: ptg_tap_bit = 4'h2;
    endcase
  endfunction : ptg_tap_bit

endpackage : ptg_pkg

//--- ptg_sync.sv
/*
  Three-stage synchroniser: a change counts once stages two and three agree.
  Assumes the input is asynchronous to mclk_in.
*/
module ptg_sync (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce_in) begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      q_out <= 1'b0;
    end else if (ce_in && (s2_r == s3_r)) begin
      q_out <= s3_r;
    end
  end
endmodule : ptg_sync

//--- ptg_divider.sv
/*
  Divider chain: optional divide-by-128 prescaler then a 15-stage counter.
  Assumes count_en_in marks source clock edges already synchronised.
*/
module ptg_divider
  import ptg_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  srst_in,
  input  wire logic                  ce_in,
  input  wire logic                  run_in,
  input  wire logic                  pre128_in,
  input  wire logic                  count_en_in,
  input  wire logic [2:0]            tap_sel_in,
  output logic                       ovf_out,
  output logic [DIV_STAGES-1:0]      count_out
);
  logic [PRE_STAGES-1:0] pre_r;
  logic                  step;
  logic [3:0]            tap;
  logic [DIV_STAGES-1:0] cnt_nxt;

  assign tap     = ptg_tap_bit(tap_sel_in);
  assign step    = count_en_in && (!pre128_in || (pre_r == 7'h7f));
  assign cnt_nxt = count_out + 15'h0001;

  always_ff @(posedge mclk_in) begin
    if (srst_in || (ce_in && !run_in)) begin
      pre_r <= PRE_ZERO;
    end else if (ce_in && count_en_in && pre128_in) begin
      pre_r <= pre_r + 7'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in || (ce_in && !run_in)) begin
      count_out <= DIV_ZERO;
    end else if (ce_in && step) begin
      count_out <= cnt_nxt;
    end
  end

  // Overflow pulse when the selected tap rises: first at half period, then every period
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      ovf_out <= 1'b0;
    end else if (ce_in) begin
      ovf_out <= run_in && step && !count_out[tap] && cnt_nxt[tap];
    end
  end
endmodule : ptg_divider

//--- ptg_top.sv
/*
  Periodic tick generator top: AXI4-Lite slave, control register, tick flag,
  interrupt level and low-power gating.
  Assumes one 200 MHz clock; osc_reference_clock arrives as an async pin.
*/
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
// Overview of operation
// - Divider chain is clocked by edges of the oscillator reference clock.
// - Run bit low holds every divider stage at zero.
// - Counting starts when run becomes one and continues while set.
// - Overflow at the selected tap sets the read-only tick flag.
// - Interrupt request asserts when flag and enable are both one.
// - Writing one to acknowledge clears the flag; zero does nothing.
// - Acknowledge bit is write-only and reads zero.
// - First tick comes near half period, later ones at exact period.
// - Undivided taps give ratios 32768 down to 8.
// - Prescaled taps give ratios 4194304 down to 1024.
// - In wait mode counting continues but register access is blocked.
// - In stop mode counting continues only if oscillator kept running.
// - Otherwise stop mode freezes the block and blocks register access.
// - System reset clears run and interrupt enable.
// - Divider chain has fifteen stages, eight selectable as taps.
// - External option selects undivided or divide-by-128 source.
module ptg_top
  import ptg_pkg::*;
(
  input  wire logic         mclk_in,
  input  wire logic         srst_in,
  input  wire logic         ce_in,
  input  wire logic         osc_reference_clock_in,
  input  wire logic         prescale128_select_in,
  input  wire logic         osc_keep_in_stop_in,
  input  wire logic         wait_mode_in,
  input  wire logic         stop_mode_in,
  input  ptg_pkg::ptg_axi_req_t axi_req_in,
  output ptg_pkg::ptg_axi_rsp_t axi_rsp_out,
  output logic              tick_irq_out
);
  import ptg_pkg::*;

  logic                  osc_sync;
  logic                  osc_prev_r;
  logic                  osc_edge;
  logic                  active;
  logic                  blocked;
  logic                  ovf;
  logic [DIV_STAGES-1:0] count;

  logic       tick_run_r;
  logic       tick_irq_enable_r;
  logic [2:0] tap_select_r;
  logic       tick_flag_r;
  logic       tick_flag_nxt;

  logic          aw_have_r;
  logic          w_have_r;
  logic [AW-1:0] aw_addr_r;
  logic [DW-1:0] w_data_r;
  logic [3:0]    w_strb_r;
  logic          wr_fire;
  logic          ack_wr;

  ptg_sync u_osc_sync (
    .mclk_in (mclk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .d_in    (osc_reference_clock_in),
    .q_out   (osc_sync)
  );

  // Stop without kept oscillator freezes the whole chain
  assign active  = !stop_mode_in || osc_keep_in_stop_in;
  assign blocked = wait_mode_in || stop_mode_in;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      osc_prev_r <= 1'b0;
    end else if (ce_in) begin
      osc_prev_r <= osc_sync;
    end
  end

  assign osc_edge = osc_sync && !osc_prev_r && active;

  ptg_divider u_div (
    .mclk_in     (mclk_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .run_in      (tick_run_r),
    .pre128_in   (prescale128_select_in),
    .count_en_in (osc_edge),
    .tap_sel_in  (tap_select_r),
    .ovf_out     (ovf),
    .count_out   (count)
  );

  // AXI write channel capture
  assign wr_fire = aw_have_r && w_have_r && !axi_rsp_out.bvalid;

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (ce_in) begin
      if (axi_req_in.awvalid && axi_rsp_out.awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= axi_req_in.awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      w_have_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (ce_in) begin
      if (axi_req_in.wvalid && axi_rsp_out.wready) begin
        w_have_r <= 1'b1;
        w_data_r <= axi_req_in.wdata;
        w_strb_r <= axi_req_in.wstrb;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      axi_rsp_out.awready <= 1'b0;
      axi_rsp_out.wready  <= 1'b0;
    end else if (ce_in) begin
      axi_rsp_out.awready <= !aw_have_r && !(axi_req_in.awvalid && axi_rsp_out.awready);
      axi_rsp_out.wready  <= !w_have_r && !(axi_req_in.wvalid && axi_rsp_out.wready);
    end
  end

  // Register writes are ignored while the processor cannot reach the block
  logic wr_ok;
  assign wr_ok  = wr_fire && (aw_addr_r == TICK_CONTROL_OFF) && w_strb_r[0] && !blocked;
  assign ack_wr = wr_ok && w_data_r[TICK_ACK_POS];

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      axi_rsp_out.bvalid <= 1'b0;
      axi_rsp_out.bresp  <= RESP_OKAY;
    end else if (ce_in) begin
      if (wr_fire) begin
        axi_rsp_out.bvalid <= 1'b1;
        axi_rsp_out.bresp  <= (aw_addr_r == TICK_CONTROL_OFF && !blocked) ? RESP_OKAY
                                                                          : RESP_SLVERR;
      end else if (axi_req_in.bready) begin
        axi_rsp_out.bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tick_run_r        <= TICK_RUN_RST;
      tick_irq_enable_r <= TICK_IRQEN_RST;
      tap_select_r      <= TAP_SEL_RST;
    end else if (ce_in && wr_ok) begin
      tick_run_r        <= w_data_r[TICK_RUN_POS];
      tick_irq_enable_r <= w_data_r[TICK_IRQEN_POS];
      tap_select_r      <= w_data_r[TAP_SEL_LSB +: 3];
    end
  end

  // Set wins over acknowledge
  always_comb begin
    tick_flag_nxt = tick_flag_r;
    if (ack_wr) begin
      tick_flag_nxt = 1'b0;
    end
    if (ovf) begin
      tick_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tick_flag_r <= 1'b0;
    end else if (ce_in) begin
      tick_flag_r <= tick_flag_nxt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      tick_irq_out <= 1'b0;
    end else if (ce_in) begin
      tick_irq_out <= tick_flag_nxt && tick_irq_enable_r;
    end
  end

  // AXI read channel
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      axi_rsp_out.arready <= 1'b0;
      axi_rsp_out.rvalid  <= 1'b0;
      axi_rsp_out.rdata   <= 32'h0000_0000;
      axi_rsp_out.rresp   <= RESP_OKAY;
    end else if (ce_in) begin
      axi_rsp_out.arready <= !axi_rsp_out.rvalid && !axi_rsp_out.arready;
      if (axi_req_in.arvalid && axi_rsp_out.arready) begin
        axi_rsp_out.rvalid <= 1'b1;
        axi_rsp_out.rresp  <= RESP_OKAY;
        axi_rsp_out.rdata  <= 32'h0000_0000;
        if (blocked) begin
          axi_rsp_out.rresp <= RESP_SLVERR;
        end else if (axi_req_in.araddr == TICK_CONTROL_OFF) begin
          axi_rsp_out.rdata <= {24'h000000, tick_flag_r, tap_select_r, 1'b0,
                                tick_irq_enable_r, tick_run_r, 1'b0};
        end else if (axi_req_in.araddr == TICK_COUNT_OFF) begin
          axi_rsp_out.rdata <= {17'h00000, count};
        end else begin
          axi_rsp_out.rresp <= RESP_SLVERR;
        end
      end else if (axi_req_in.rready) begin
        axi_rsp_out.rvalid <= 1'b0;
      end
    end
  end

  a_flag_on_ovf: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && ovf |=> tick_flag_r) else $error("tick flag not set on overflow");

  a_ack_clears: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && ack_wr && !ovf |=> !tick_flag_r) else $error("acknowledge did not clear flag");

  a_irq_level: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in |=> tick_irq_out == (tick_flag_r && $past(tick_irq_enable_r)))
    else $error("irq level mismatch");

  a_run_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && !tick_run_r |=> count == DIV_ZERO) else $error("count not held at zero");

  a_reset_ctrl: assert property (@(posedge mclk_in)
    srst_in |=> !tick_run_r && !tick_irq_enable_r) else $error("reset left run or enable");

  a_ack_reads0: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && axi_req_in.arvalid && axi_rsp_out.arready && !axi_rsp_out.rvalid &&
    (axi_req_in.araddr == TICK_CONTROL_OFF) |=> !axi_rsp_out.rdata[TICK_ACK_POS])
    else $error("acknowledge bit read as one");

  a_stop_freeze: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && stop_mode_in && !osc_keep_in_stop_in ##1 ce_in |-> $stable(count))
    else $error("count moved in stop");

  a_blocked_wr: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && wr_fire && blocked |=> $stable(tap_select_r))
    else $error("write reached register while blocked");
endmodule : ptg_top

//--- tb_top.sv
/*
  Self-checking bench for the periodic tick generator: AXI4-Lite read and
  write tasks, tap periods, acknowledge, masking and low-power modes.
  Assumes ptg_pkg and ptg_top; the oscillator pin runs at one eighth of mclk_in.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ptg_pkg::*;

  localparam int LIMIT = 90000;
  logic         mclk_in = 1'b0;
  logic         srst_in = 1'b1;
  logic         osc = 1'b0, pre = 1'b0, keep = 1'b0, wt = 1'b0, stp = 1'b0;
  logic [1:0]   ocnt = 2'h0;
  ptg_axi_req_t req = '0;
  ptg_axi_rsp_t rsp;
  logic         irq;
  int           errors = 0, n_tests = 0, cyc = 0;

  ptg_top uut (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(1'b1),
    .osc_reference_clock_in(osc), .prescale128_select_in(pre),
    .osc_keep_in_stop_in(keep), .wait_mode_in(wt), .stop_mode_in(stp),
    .axi_req_in(req), .axi_rsp_out(rsp), .tick_irq_out(irq));

  always #2.5 mclk_in = ~mclk_in;

  // Oscillator pin toggles every 4 cycles; cycle counter cuts a hang
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    ocnt <= ocnt + 2'h1;
    if (ocnt == 2'h3) osc <= ~osc;
    if (cyc == LIMIT) begin
      errors++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] ctl(input logic [2:0] tap, input logic ak, ie, run);
    return {24'h0, 1'b0, tap, ak, ie, run, 1'b0};
  endfunction : ctl

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge mclk_in);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        chk("bresp", {30'h0, rsp.bresp}, {30'h0, er});
        req.bready <= 1'b0;
        break;
      end
    end
    if (i == 100) chk("bvalid", 32'h0, 32'h1);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    int i;
    d = 32'h0;
    @(posedge mclk_in);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge mclk_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        d = rsp.rdata;
        chk("rresp", {30'h0, rsp.rresp}, {30'h0, er});
        req.rready <= 1'b0;
        break;
      end
    end
    if (i == 100) chk("rvalid", 32'h0, 32'h1);
  endtask : rd

  task automatic wait_irq(input int limit, output int n);
    int i;
    n = -1;
    for (i = 0; i < limit; i++) begin
      @(posedge mclk_in);
      if (irq === 1'b1) begin
        n = i + 1;
        break;
      end
    end
  endtask : wait_irq

  initial begin
    logic [31:0] d;
    int          n, t0, k, ratio;
    logic [2:0]  code;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rd(TICK_CONTROL_OFF, d, RESP_OKAY);
    chk("ctl_reset", d, 32'h0);
    rd(TICK_COUNT_OFF, d, RESP_OKAY);
    chk("count_reset", d, 32'h0);
    rd(4'h8, d, RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    $display("test reset done");

    for (k = 0; k < 6; k++) begin
      code = 3'(7 - k);
      ratio = (k == 5) ? 2048 : (8 << k);
      wr(TICK_CONTROL_OFF, ctl(code, 1'b0, 1'b1, 1'b0), RESP_OKAY);
      wr(TICK_CONTROL_OFF, ctl(code, 1'b0, 1'b1, 1'b1), RESP_OKAY);
      wait_irq(ratio * 8, n);
      chk("first_tick", 32'(n >= ratio * 4 - 16 && n <= ratio * 4 + 16), 32'h1);
      t0 = cyc;
      wr(TICK_CONTROL_OFF, ctl(code, 1'b1, 1'b1, 1'b1), RESP_OKAY);
      @(posedge mclk_in);
      chk("irq_after_ack", irq, 32'h0);
      rd(TICK_CONTROL_OFF, d, RESP_OKAY);
      chk("ack_reads_zero", d, ctl(code, 1'b0, 1'b1, 1'b1));
      wait_irq(ratio * 8 + 16, n);
      chk("period", cyc - t0, ratio * 8);
      wr(TICK_CONTROL_OFF, ctl(code, 1'b0, 1'b1, 1'b1), RESP_OKAY);
      rd(TICK_CONTROL_OFF, d, RESP_OKAY);
      chk("flag_kept", d, 32'h80 | ctl(code, 1'b0, 1'b1, 1'b1));
      wr(TICK_CONTROL_OFF, ctl(code, 1'b1, 1'b1, 1'b0), RESP_OKAY);
      rd(TICK_COUNT_OFF, d, RESP_OKAY);
      chk("count_cleared", d, 32'h0);
    end
    $display("test taps done");

    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b0, 1'b0, 1'b1), RESP_OKAY);
    wait_irq(200, n);
    chk("irq_masked", n, -1);
    rd(TICK_CONTROL_OFF, d, RESP_OKAY);
    chk("flag_masked", d, 32'h80 | ctl(3'h7, 1'b0, 1'b0, 1'b1));
    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b1, 1'b1, 1'b1), RESP_OKAY);
    wt <= 1'b1;
    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b1, 1'b0, 1'b0), RESP_SLVERR);
    wait_irq(200, n);
    chk("wait_counts", 32'(n > 0), 32'h1);
    wt <= 1'b0;
    rd(TICK_CONTROL_OFF, d, RESP_OKAY);
    chk("wait_write_ignored", d, 32'h80 | ctl(3'h7, 1'b0, 1'b1, 1'b1));
    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b1, 1'b1, 1'b1), RESP_OKAY);
    stp <= 1'b1;
    rd(TICK_CONTROL_OFF, d, RESP_SLVERR);
    chk("stop_read", d, 32'h0);
    wait_irq(300, n);
    chk("stop_frozen", n, -1);
    keep <= 1'b1;
    wait_irq(200, n);
    chk("stop_keep_counts", 32'(n > 0), 32'h1);
    stp <= 1'b0;
    keep <= 1'b0;
    $display("test low power done");

    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b1, 1'b1, 1'b0), RESP_OKAY);
    pre <= 1'b1;
    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b0, 1'b1, 1'b1), RESP_OKAY);
    wait_irq(9000, n);
    t0 = cyc;
    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b1, 1'b1, 1'b1), RESP_OKAY);
    wait_irq(8300, n);
    chk("prescaled_period", cyc - t0, 1024 * 8);
    wr(TICK_CONTROL_OFF, ctl(3'h7, 1'b1, 1'b1, 1'b0), RESP_OKAY);
    $display("test prescale done");
    wrap_up();
  end
endmodule : tb_top
